// [hdl/sync_two_ff.sv]
`timescale 1ns/1ps
module sync_two_ff #(
   parameter int WIDTH = 1
) (
   input wire logic clk, // system clock
   input wire logic reset, // async reset, active high
   input wire logic [WIDTH-1:0] din, // asynchronous input
   output logic [WIDTH-1:0] dout // synchronised output
);
   logic [WIDTH-1:0] meta_q;

   // two flip-flop chain; only the second stage is read
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         meta_q <= '0;
         dout <= '0;
      end
      else
      begin
         meta_q <= din;
         dout <= meta_q;
      end
   end
endmodule // sync_two_ff

// [hdl/synth_ctrl_pkg.sv]
package synth_ctrl_pkg;
   // apb geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int STRB_W = 4;
   localparam int REG_W = 16;

   // register indices and byte addresses (index times four)
   localparam logic [ADDR_W-1:0] MAIN_IDX = 8'h00;
   localparam logic [ADDR_W-1:0] AUX_IDX = 8'h01;
   localparam logic [ADDR_W-1:0] MAIN_ADDR = 8'h00;
   localparam logic [ADDR_W-1:0] AUX_ADDR = 8'h04;

   // main_synth_control fields
   localparam int PHASE_ALIGN_BIT = 14;
   localparam int OUT_SILENCE_BIT = 9;
   localparam int SPEED_HI = 8;
   localparam int SPEED_LO = 7;
   localparam int CAL_TRIG_BIT = 3;
   localparam int MUX_SRC_BIT = 2;
   localparam int SOFT_RST_BIT = 1;
   localparam int SLEEP_BIT = 0;
   localparam logic [REG_W-1:0] MAIN_RESET = 16'h200C;

   // aux_pin_and_cal_clock_config fields
   localparam int DRIVE_BIT = 3;
   localparam int DIV_HI = 2;
   localparam int DIV_LO = 0;
   localparam logic [REG_W-1:0] AUX_RESET = 16'h080C;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
      logic [STRB_W-1:0] pstrb;
   } apb_req_t;

   typedef struct packed {
      logic [DATA_W-1:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_t;
endpackage

// [hdl/synth_top_control_regs.sv]
// Notes on behaviour
// - phase align bit drives feedback divider routing
// - zero-to-one write of align bit pulses sync
// - silence bit mutes both outputs while calibrating
// - write with trigger bit set starts calibration
// - source bit picks readback or lock detect
// - soft reset holds registers and engines at default
// - sleep bit powers the device down
// - aux register resets to 0x80C
// - drive bit tri-states or drives the pin
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module synth_top_control_regs
   import synth_ctrl_pkg::*;
(
   input wire logic clk, // 100 MHz system clock
   input wire logic reset, // async reset, active high
   input synth_ctrl_pkg::apb_req_t apb_req, // apb request group
   output synth_ctrl_pkg::apb_rsp_t apb_rsp, // apb answer group
   input wire logic lock_detect, // lock indication, asynchronous
   input wire logic readback_bit, // readback serial data, asynchronous
   input wire logic cal_busy, // calibration running, same clock
   output logic osc_phase_align_en, // phase alignment mode level
   output logic sync_pulse, // one-cycle synchronisation pulse
   output logic [1:0] cal_pfd_speed_range, // calibration speed range
   output logic freq_cal_trigger, // one-cycle calibration start
   output logic rf_output_a_mute, // mute rf output a
   output logic rf_output_b_mute, // mute rf output b
   output logic soft_reset, // soft reset to engines, level
   output logic sleep_request, // power-down request, level
   output logic [2:0] cal_clk_div, // calibration clock divider exponent
   output logic multiplexed_output_pin_o, // mux pin output value
   output logic multiplexed_output_pin_oe // mux pin output enable
);
   import synth_ctrl_pkg::*;

   typedef struct packed {
      logic [REG_W-1:0] main_synth_control;
      logic [REG_W-1:0] aux_pin_and_cal_clock_config;
      logic sync_pulse;
      logic cal_start;
      logic [DATA_W-1:0] rdata;
      logic mux_pin;
   } state_t;

   state_t state_q;
   state_t state_d;
   // synchronised pin inputs
   logic [1:0] pin_sync;
   logic lock_s;
   logic readback_s;
   // decoded bus phases, register hits and write strobes
   logic setup_ph;
   logic access_ph;
   logic hit_main;
   logic hit_aux;
   logic wr_main;
   logic wr_aux;
   // write data merged into the present register values
   logic [REG_W-1:0] main_new;
   logic [REG_W-1:0] aux_new;

   // merge write data into a register by byte lane; lanes 2 and 3
   // fall outside the 16-bit registers and are dropped
   function automatic logic [REG_W-1:0] lane_merge(
      input logic [REG_W-1:0] old_v,
      input logic [DATA_W-1:0] wd,
      input logic [STRB_W-1:0] strb
   );
      logic [REG_W-1:0] r;
      r = old_v;
      if (strb[0])
         r[7:0] = wd[7:0];
      if (strb[1])
         r[15:8] = wd[15:8];
      return r;
   endfunction

   // zero-extend a register to the bus width
   function automatic logic [DATA_W-1:0] widen(input logic [REG_W-1:0] v);
      return {{(DATA_W-REG_W){1'b0}}, v};
   endfunction

   // read word for the addressed register; holes in the map read zero
   function automatic logic [DATA_W-1:0] read_word(
      input state_t s,
      input logic main_sel,
      input logic aux_sel
   );
      logic [DATA_W-1:0] w;
      w = '0;
      if (main_sel)
         w = widen(s.main_synth_control);
      else if (aux_sel)
         w = widen(s.aux_pin_and_cal_clock_config);
      return w;
   endfunction

   // force every register field and both pulses to default while soft reset is held; the
   // bit itself survives so that the host can write it back to zero
   function automatic state_t hold_defaults(input state_t s);
      state_t r;
      r = s;
      r.main_synth_control = MAIN_RESET;
      r.main_synth_control[SOFT_RST_BIT] = 1'b1;
      r.aux_pin_and_cal_clock_config = AUX_RESET;
      // a write that enters soft reset must not start anything
      r.sync_pulse = 1'b0;
      r.cal_start = 1'b0;
      return r;
   endfunction

   // mux pin source: lock indication when set, readback data when clear
   function automatic logic pick_mux_source(
      input logic src_sel,
      input logic lock_v,
      input logic readback_v
   );
      return src_sel ? lock_v : readback_v;
   endfunction

   // pin-side inputs pass two flip-flops
   sync_two_ff #(
      .WIDTH(2)
   ) u_pin_sync (
      .clk(clk),
      .reset(reset),
      .din({lock_detect, readback_bit}),
      .dout(pin_sync)
   );
   assign lock_s = pin_sync[1];
   assign readback_s = pin_sync[0];

   // apb phase and address decode
   assign setup_ph = apb_req.psel & ~apb_req.penable;
   assign access_ph = apb_req.psel & apb_req.penable;
   assign hit_main = (apb_req.paddr == MAIN_ADDR);
   assign hit_aux = (apb_req.paddr == AUX_ADDR);
   // a write lands at the edge that ends its access phase
   assign wr_main = access_ph & apb_req.pwrite & hit_main;
   assign wr_aux = access_ph & apb_req.pwrite & hit_aux;
   assign main_new = lane_merge(state_q.main_synth_control,
                                apb_req.pwdata, apb_req.pstrb);
   assign aux_new = lane_merge(state_q.aux_pin_and_cal_clock_config,
                               apb_req.pwdata, apb_req.pstrb);

   // next-state logic for registers, pulses and read data
   always_comb
   begin
      state_d = state_q;
      // pulses last one cycle unless a write raises them again
      state_d.sync_pulse = 1'b0;
      state_d.cal_start = 1'b0;
      // capture read data in setup so it is a flop in access
      if (setup_ph)
         state_d.rdata = read_word(state_q, hit_main, hit_aux);
      if (wr_main)
      begin
         state_d.main_synth_control = main_new;
         // rising edge of the align bit fires one sync pulse
         state_d.sync_pulse = main_new[PHASE_ALIGN_BIT] &
            ~state_q.main_synth_control[PHASE_ALIGN_BIT];
         // a write with the trigger bit set starts calibration unless soft reset ends up set
         state_d.cal_start = main_new[CAL_TRIG_BIT];
      end
      if (wr_aux)
         state_d.aux_pin_and_cal_clock_config = aux_new;
      // soft reset holds both registers and both pulses at default except its own bit; read data and mux pin still update
      if (state_d.main_synth_control[SOFT_RST_BIT])
         state_d = hold_defaults(state_d);
      // the pin follows the source that the stored value selects
      state_d.mux_pin = pick_mux_source(
         state_d.main_synth_control[MUX_SRC_BIT], lock_s,
         readback_s);
   end

   // state register
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         state_q.main_synth_control <= MAIN_RESET;
         state_q.aux_pin_and_cal_clock_config <= AUX_RESET;
         state_q.sync_pulse <= 1'b0;
         state_q.cal_start <= 1'b0;
         state_q.rdata <= '0;
         state_q.mux_pin <= 1'b0;
      end
      else
         state_q <= state_d;
   end

   // apb answer: zero wait states, error on unmapped access
   assign apb_rsp.pready = 1'b1;
   assign apb_rsp.pslverr = access_ph & ~(hit_main | hit_aux);
   assign apb_rsp.prdata = state_q.rdata;

   // control outputs from register fields
   assign osc_phase_align_en =
      state_q.main_synth_control[PHASE_ALIGN_BIT];
   // pulses come straight from flops and last exactly one cycle
   assign sync_pulse = state_q.sync_pulse;
   assign cal_pfd_speed_range =
      state_q.main_synth_control[SPEED_HI:SPEED_LO];
   assign freq_cal_trigger = state_q.cal_start;
   // mute follows cal_busy in the same cycle, so the outputs go quiet
   // as the engine starts rather than one cycle after it
   assign rf_output_a_mute =
      state_q.main_synth_control[OUT_SILENCE_BIT] & cal_busy;
   assign rf_output_b_mute =
      state_q.main_synth_control[OUT_SILENCE_BIT] & cal_busy;
   assign soft_reset = state_q.main_synth_control[SOFT_RST_BIT];
   assign sleep_request = state_q.main_synth_control[SLEEP_BIT];
   assign cal_clk_div =
      state_q.aux_pin_and_cal_clock_config[DIV_HI:DIV_LO];

   // mux pin drive: enable low means high impedance
   assign multiplexed_output_pin_o = state_q.mux_pin;
   assign multiplexed_output_pin_oe =
      state_q.aux_pin_and_cal_clock_config[DRIVE_BIT];
endmodule // synth_top_control_regs

// [verification/synth_ctrl_sva.sv]
`timescale 1ns/1ps
module synth_ctrl_sva
   import synth_ctrl_pkg::*;
(
   input wire logic clk, // clock
   input wire logic reset, // reset
   input synth_ctrl_pkg::apb_req_t apb_req, // request
   input synth_ctrl_pkg::apb_rsp_t apb_rsp, // answer
   input wire logic cal_busy, // calibrating
   input wire logic osc_phase_align_en, // align
   input wire logic sync_pulse, // sync
   input wire logic [1:0] cal_pfd_speed_range, // range
   input wire logic freq_cal_trigger, // trigger
   input wire logic rf_output_a_mute, // mute a
   input wire logic rf_output_b_mute, // mute b
   input wire logic soft_reset, // soft reset
   input wire logic sleep_request, // sleep
   input wire logic [2:0] cal_clk_div, // divider
   input wire logic multiplexed_output_pin_oe // pin enable
);
   logic wr; // write taken this edge
   logic wm; // full main write outside soft reset
   logic wa; // aux write outside soft reset
   // write qualifiers
   assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
   assign wm = wr && apb_req.paddr == MAIN_ADDR && apb_req.pstrb[1:0] == 2'h3
      && !apb_req.pwdata[1] && !soft_reset;
   assign wa = wr && apb_req.paddr == AUX_ADDR && apb_req.pstrb[0]
      && !soft_reset;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   AST_MUTE: assert property (
      (rf_output_a_mute || rf_output_b_mute) |-> cal_busy
      && rf_output_a_mute == rf_output_b_mute) else $error("bad mute");
   AST_SYNC: assert property (
      sync_pulse |-> osc_phase_align_en && !$past(osc_phase_align_en))
      else $error("sync without rise");
   AST_TRIG: assert property (
      freq_cal_trigger |-> $past(wr && apb_req.paddr == MAIN_ADDR
      && apb_req.pwdata[3])) else $error("trigger without write");
   AST_TRIG_GO: assert property (
      wm && apb_req.pwdata[3] |=> freq_cal_trigger) else $error("no trigger");
   AST_SRST: assert property (
      soft_reset |-> cal_clk_div == 3'h4 && multiplexed_output_pin_oe
      && !sleep_request && !sync_pulse && !freq_cal_trigger)
      else $error("soft reset not default");
   AST_MAIN_WR: assert property (
      wm |=> sleep_request == $past(apb_req.pwdata[0])
      && cal_pfd_speed_range == $past(apb_req.pwdata[8:7]))
      else $error("main write lost");
   AST_AUX_WR: assert property (
      wa |=> multiplexed_output_pin_oe == $past(apb_req.pwdata[3])
      && cal_clk_div == $past(apb_req.pwdata[2:0])) else $error("aux lost");
   AST_ALIGN_HOLD: assert property (
      !(wr && apb_req.paddr == MAIN_ADDR) |=> $stable(osc_phase_align_en))
      else $error("align moved");
   cover property (sync_pulse);
   cover property (soft_reset);
   AST_AUX_SRST_RD: assert property (
      soft_reset && $past(soft_reset) && apb_req.psel && apb_req.penable
      && !apb_req.pwrite && apb_req.paddr == AUX_ADDR
      |-> apb_rsp.prdata == {16'h0, AUX_RESET}) else $error("aux read");
   cover property (rf_output_a_mute);
   cover property (freq_cal_trigger);
endmodule // synth_ctrl_sva
bind synth_top_control_regs synth_ctrl_sva chk (.clk(clk), .reset(reset),
   .apb_req(apb_req), .apb_rsp(apb_rsp), .cal_busy(cal_busy),
   .osc_phase_align_en(osc_phase_align_en), .sync_pulse(sync_pulse),
   .cal_pfd_speed_range(cal_pfd_speed_range),
   .freq_cal_trigger(freq_cal_trigger), .rf_output_a_mute(rf_output_a_mute),
   .rf_output_b_mute(rf_output_b_mute), .soft_reset(soft_reset),
   .sleep_request(sleep_request), .cal_clk_div(cal_clk_div),
   .multiplexed_output_pin_oe(multiplexed_output_pin_oe));

// [verification/synth_top_control_regs_tb.sv]
`timescale 1ns/1ps
module synth_top_control_regs_tb;
   import synth_ctrl_pkg::*;
   logic clk = 0;
   logic reset = 1;
   logic lock_detect = 0;
   logic readback_bit = 0;
   logic cal_busy = 0;
   apb_req_t apb_req = '0;
   apb_rsp_t apb_rsp;
   logic osc_phase_align_en, sync_pulse, freq_cal_trigger, soft_reset;
   logic rf_output_a_mute, rf_output_b_mute, sleep_request;
   logic multiplexed_output_pin_o, multiplexed_output_pin_oe;
   logic [1:0] cal_pfd_speed_range;
   logic [2:0] cal_clk_div;
   logic [31:0] rd;
   logic err;
   logic [1:0] pul;
   int error_cnt = 0;
   int samples_checked = 0;
   int cyc = 0;
   // reserved fields as the host must write them
   localparam logic [15:0] RSV = 16'h2010;
   synth_top_control_regs uut (.clk, .reset, .apb_req, .apb_rsp,
      .lock_detect, .readback_bit, .cal_busy, .osc_phase_align_en,
      .sync_pulse, .cal_pfd_speed_range, .freq_cal_trigger,
      .rf_output_a_mute, .rf_output_b_mute, .soft_reset, .sleep_request,
      .cal_clk_div, .multiplexed_output_pin_o, .multiplexed_output_pin_oe);
   // clock
   initial
   begin
      forever #5 clk = ~clk;
   end
   // hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         error_cnt++;
         complete_run;
      end
   end
   task automatic complete_run;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] s, e);
      samples_checked++;
      if (s !== e)
      begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   // one apb transfer, then the pulses of the cycle after it
   task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      apb_req <= '{1'b1, 1'b0, w, a, {16'h0, d}, 4'hF};
      @(posedge clk);
      apb_req.penable <= 1'b1;
      do @(posedge clk); while (apb_rsp.pready !== 1'b1);
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req <= '0;
      @(posedge clk);
      pul = {sync_pulse, freq_cal_trigger};
   endtask
   task automatic t_defaults;
      apb(0, MAIN_ADDR, 0);
      check("main", rd, 32'h200C);
      apb(0, AUX_ADDR, 0);
      check("aux", rd, 32'h080C);
      check("oe", multiplexed_output_pin_oe, 1);
      apb(0, 8'h08, 0);
      check("slverr", err, 1);
      check("hole", rd, 0);
   endtask
   task automatic t_sync_cal;
      // pulse soft reset before programming anything
      apb(1, MAIN_ADDR, RSV | 16'h0002);
      check("pre_srst", soft_reset, 1);
      apb(1, MAIN_ADDR, RSV);
      check("pre_rel", soft_reset, 0);
      apb(1, MAIN_ADDR, RSV | 16'h4008);
      check("p1", pul, 2'b11);
      check("align", osc_phase_align_en, 1);
      apb(1, MAIN_ADDR, RSV | 16'h4008);
      check("p2", pul, 2'b01);
      apb(1, MAIN_ADDR, RSV | 16'h4000);
      check("p3", pul, 2'b00);
      apb(0, MAIN_ADDR, 0);
      check("rb", rd, {16'h0, RSV | 16'h4000});
   endtask
   task automatic t_mute_range;
      apb(1, MAIN_ADDR, RSV | 16'h0201);
      cal_busy <= 1;
      @(posedge clk);
      check("mute", {rf_output_a_mute, rf_output_b_mute}, 2'b11);
      check("sleep", sleep_request, 1);
      for (int i = 0; i < 4; i++)
      begin
         apb(1, MAIN_ADDR, RSV | 16'(i << 7));
         check("range", cal_pfd_speed_range, i[1:0]);
      end
      check("unmute", rf_output_a_mute, 0);
      cal_busy <= 0;
   endtask
   task automatic t_pin;
      lock_detect <= 1;
      apb(1, MAIN_ADDR, RSV | 16'h0004);
      check("lock", multiplexed_output_pin_o, 1);
      apb(1, MAIN_ADDR, RSV);
      repeat (3) @(posedge clk);
      check("rdbk0", multiplexed_output_pin_o, 0);
      readback_bit <= 1;
      repeat (4) @(posedge clk);
      check("rdbk1", multiplexed_output_pin_o, 1);
      apb(1, AUX_ADDR, 16'h0801);
      check("tri", {multiplexed_output_pin_oe, cal_clk_div}, 4'h1);
   endtask
   task automatic t_soft_reset;
      apb(1, MAIN_ADDR, RSV | 16'h000B);
      check("srst", {soft_reset, pul}, 3'b100);
      apb(1, AUX_ADDR, 16'h0805);
      apb(0, AUX_ADDR, 0);
      check("aux", rd, 32'h080C);
      apb(0, MAIN_ADDR, 0);
      check("main", rd, 32'h200E);
      apb(1, MAIN_ADDR, RSV);
      check("rel", soft_reset, 0);
   endtask
   // main sequence
   initial
   begin
      repeat (6) @(posedge clk);
      reset <= 0;
      t_defaults;
      t_sync_cal;
      t_mute_range;
      t_pin;
      t_soft_reset;
      complete_run;
   end
endmodule // synth_top_control_regs_tb
